// [shm_pkg.sv]
// Package for the SD host interrupt mask and FIFO port register bank
package shm_pkg;
   localparam logic [11:0] SHM_OFF_MASK     = 12'h03C;
   localparam logic [11:0] SHM_OFF_WORDCNT  = 12'h048;
   localparam logic [11:0] SHM_OFF_FIFODATA = 12'h080;
   localparam logic [11:0] SHM_OFF_STATUS   = 12'h034;
   localparam logic [11:0] SHM_OFF_CLEAR    = 12'h038;
   localparam logic [31:0] SHM_MASK_RESET   = 32'h0000_0000;
   localparam logic [31:0] SHM_CNT_RESET    = 32'h0000_0000;
   localparam int          SHM_FLAG_W       = 24;
   localparam int          SHM_CNT_W        = 24;
   // Sticky flags live in 23:22 and 10:0, live flags in 21:11
   localparam logic [23:0] SHM_STICKY_BITS  = 24'hC0_07FF;
   localparam int          SHM_HALF_ROOM    = 8;
   localparam int          SHM_WORD_BYTES   = 4;

   typedef struct packed {
      logic [23:0] mask;
      logic [23:0] sticky;
      logic [23:0] count;
      logic [31:0] prdata;
      logic        irq;
   } shm_state_t;

   // Live FIFO/activity levels from the host core
   typedef struct packed {
      logic       cmd_active;
      logic       tx_active;
      logic       rx_active;
      logic       tx_full;
      logic       rx_half_full;
      logic       rx_full;
      logic       tx_empty;
      logic       rx_empty;
      logic       tx_has_words;
      logic       rx_has_words;
   } shm_live_t;
endpackage : shm_pkg

// [shm_regs.sv]
// SD host interrupt mask, FIFO word counter and FIFO data port over APB
//
// The APB register port was decided locally.
`timescale 1ns/1ps
module shm_regs
   import shm_pkg::*;
#(
   parameter int TX_DEPTH = 32
) (
   input  wire logic                  pclk,
   input  wire logic                  presetn,
   input  wire logic                  psel,
   input  wire logic                  penable,
   input  wire logic                  pwrite,
   input  wire logic [11:0]           paddr,
   input  wire logic [31:0]           pwdata,
   output logic      [31:0]           prdata,
   output logic                       pready,
   output logic                       pslverr,
   input  wire logic [SHM_FLAG_W-1:0] event_pulse,
   input  wire shm_live_t             live,
   input  wire logic [$clog2(TX_DEPTH+1)-1:0] tx_level,
   input  wire logic                  len_load,
   input  wire logic [24:0]           len_bytes,
   input  wire logic                  word_moved,
   output logic                       tx_push,
   output logic      [31:0]           tx_data,
   output logic                       rx_pop,
   input  wire logic [31:0]           rx_data,
   output logic                       irq
);

   shm_state_t st;
   shm_state_t next_st;
   logic [23:0] flags;
   logic        wr_acc;
   logic        rd_acc;
   logic        tx_half_empty;
   logic        bad_addr;

   // Bytes to words, rounding a partial tail up
   function automatic logic [23:0] shm_words(input logic [24:0] nbytes);
      logic [24:0] sum;
      sum = nbytes + 25'(SHM_WORD_BYTES - 1);
      return sum[24:2];
   endfunction : shm_words

   function automatic logic shm_known(input logic [11:0] a);
      return a == SHM_OFF_MASK || a == SHM_OFF_WORDCNT || a == SHM_OFF_FIFODATA
          || a == SHM_OFF_STATUS || a == SHM_OFF_CLEAR;
   endfunction : shm_known

   assign tx_half_empty = (TX_DEPTH - int'(tx_level)) >= SHM_HALF_ROOM;

   // Live bits follow the core directly
   always_comb begin
      flags        = st.sticky & SHM_STICKY_BITS;
      flags[11]    = live.cmd_active;
      flags[12]    = live.tx_active;
      flags[13]    = live.rx_active;
      flags[14]    = tx_half_empty;
      flags[15]    = live.rx_half_full;
      flags[16]    = live.tx_full;
      flags[17]    = live.rx_full;
      flags[18]    = live.tx_empty;
      flags[19]    = live.rx_empty;
      flags[20]    = live.tx_has_words;
      flags[21]    = live.rx_has_words;
   end

   assign wr_acc   = psel && penable && pwrite;
   assign rd_acc   = psel && penable && !pwrite;
   assign bad_addr = !shm_known(paddr);
   assign pready   = 1'b1;
   assign pslverr  = psel && penable && bad_addr;

   always_comb begin
      next_st = st;
      // Set beats clear so a same-cycle event is not lost
      if (wr_acc && paddr == SHM_OFF_CLEAR) begin
         next_st.sticky = st.sticky & ~pwdata[23:0];
      end
      next_st.sticky = (next_st.sticky | event_pulse) & SHM_STICKY_BITS;
      if (wr_acc && paddr == SHM_OFF_MASK) begin
         next_st.mask = pwdata[23:0];
      end
      if (len_load) begin
         next_st.count = shm_words(len_bytes);
      end else if (word_moved && st.count != 24'h00_0000) begin
         next_st.count = st.count - 24'h00_0001;
      end
      next_st.prdata = 32'h0000_0000;
      if (psel && !penable && !pwrite) begin
         case (paddr)
            SHM_OFF_MASK:     next_st.prdata = {8'h00, st.mask};
            SHM_OFF_WORDCNT:  next_st.prdata = {8'h00, st.count};
            SHM_OFF_FIFODATA: next_st.prdata = 32'h0000_0000;
            SHM_OFF_STATUS:   next_st.prdata = {8'h00, flags};
            default:          next_st.prdata = 32'h0000_0000;
         endcase
      end else begin
         next_st.prdata = st.prdata;
      end
      next_st.irq = |(flags & st.mask);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st.mask   <= SHM_MASK_RESET[23:0];
         st.sticky <= 24'h00_0000;
         st.count  <= SHM_CNT_RESET[23:0];
         st.prdata <= 32'h0000_0000;
         st.irq    <= 1'b0;
      end else begin
         st <= next_st;
      end
   end

   // FIFO data reads bypass the registered path so the pop and data align
   assign prdata  = (paddr == SHM_OFF_FIFODATA) ? rx_data : st.prdata;
   assign tx_push = wr_acc && paddr == SHM_OFF_FIFODATA;
   assign tx_data = pwdata;
   assign rx_pop  = rd_acc && paddr == SHM_OFF_FIFODATA;
   assign irq     = st.irq;

   a_mask_gates_irq: assert property (@(posedge pclk) disable iff (!presetn)
      $past(flags & st.mask, 1) == 24'h00_0000 |-> !irq)
      else $error("irq high with no unmasked flag");
   a_mask_reset_zero: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(presetn) |-> st.mask == 24'h00_0000)
      else $error("mask not zero after reset");
   a_mask_write_takes: assert property (@(posedge pclk) disable iff (!presetn)
      wr_acc && paddr == SHM_OFF_MASK |=> st.mask == $past(pwdata[23:0]))
      else $error("mask write lost");
   a_irq_follows: assert property (@(posedge pclk) disable iff (!presetn)
      |(flags & st.mask) |=> irq)
      else $error("irq missed unmasked flag");
   a_count_load: assert property (@(posedge pclk) disable iff (!presetn)
      len_load |=> st.count == shm_words($past(len_bytes)))
      else $error("word count load wrong");
   a_count_step: assert property (@(posedge pclk) disable iff (!presetn)
      !len_load && word_moved && st.count != 24'h00_0000 |=> st.count == $past(st.count) - 24'h00_0001)
      else $error("word count did not step");
   a_sticky_set: assert property (@(posedge pclk) disable iff (!presetn)
      event_pulse[0] |=> st.sticky[0])
      else $error("sticky flag lost");
   a_live_no_store: assert property (@(posedge pclk) disable iff (!presetn)
      st.sticky[21:11] == 11'h000)
      else $error("live flag stored");
   a_fifo_push: assert property (@(posedge pclk) disable iff (!presetn)
      psel && penable && pwrite && paddr == SHM_OFF_FIFODATA |-> tx_push && tx_data == pwdata)
      else $error("fifo push missing");
   a_half_empty: assert property (@(posedge pclk) disable iff (!presetn)
      int'(tx_level) <= TX_DEPTH - 8 |-> flags[14])
      else $error("half empty flag missing");

   // Bus steps and the word count load shared by the register checks below
   sequence s_mask_write;
      wr_acc && paddr == SHM_OFF_MASK;
   endsequence

   sequence s_clear_write;
      wr_acc && paddr == SHM_OFF_CLEAR;
   endsequence

   sequence s_setup_read;
      psel && !penable && !pwrite;
   endsequence

   sequence s_count_load;
      len_load;
   endsequence

   // Mask register
   a_mask_hold: assert property (@(posedge pclk) disable iff (!presetn)
      !(wr_acc && paddr == SHM_OFF_MASK) |=> $stable(st.mask))
      else $error("mask changed without a write");

   a_mask_write_seq: assert property (@(posedge pclk) disable iff (!presetn)
      s_mask_write |=> st.mask == $past(pwdata[23:0]))
      else $error("mask write did not land");

   a_read_mask: assert property (@(posedge pclk) disable iff (!presetn)
      s_setup_read ##0 paddr == SHM_OFF_MASK |=> st.prdata == {8'h00, $past(st.mask)})
      else $error("mask read wrong");

   a_irq_after_reset: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(presetn) |-> !irq)
      else $error("irq high after reset");

   a_mask_zero_quiet: assert property (@(posedge pclk) disable iff (!presetn)
      st.mask == 24'h00_0000 |=> !irq)
      else $error("irq with mask all zero");

   // Each group of mask bits reaches the interrupt
   a_err_gate: assert property (@(posedge pclk) disable iff (!presetn)
      |(flags[5:0] & st.mask[5:0]) |=> irq)
      else $error("error flag did not raise irq");

   a_evt_gate: assert property (@(posedge pclk) disable iff (!presetn)
      |(flags[10:6] & st.mask[10:6]) |=> irq)
      else $error("event flag did not raise irq");

   a_act_gate: assert property (@(posedge pclk) disable iff (!presetn)
      |(flags[13:11] & st.mask[13:11]) |=> irq)
      else $error("activity flag did not raise irq");

   a_level_gate: assert property (@(posedge pclk) disable iff (!presetn)
      |(flags[21:14] & st.mask[21:14]) |=> irq)
      else $error("level flag did not raise irq");

   a_card_gate: assert property (@(posedge pclk) disable iff (!presetn)
      |(flags[23:22] & st.mask[23:22]) |=> irq)
      else $error("card flag did not raise irq");

   // Live and sticky flags
   a_live_activity: assert property (@(posedge pclk) disable iff (!presetn)
      flags[13:11] == {live.rx_active, live.tx_active, live.cmd_active})
      else $error("activity flags not live");

   a_live_levels: assert property (@(posedge pclk) disable iff (!presetn)
      flags[21:15] == {live.rx_has_words, live.tx_has_words, live.rx_empty, live.tx_empty,
                       live.rx_full, live.tx_full, live.rx_half_full})
      else $error("level flags not live");

   a_half_empty_off: assert property (@(posedge pclk) disable iff (!presetn)
      int'(tx_level) > TX_DEPTH - 8 |-> !flags[14])
      else $error("half empty flag without room");

   a_card_sticky: assert property (@(posedge pclk) disable iff (!presetn)
      event_pulse[22] |=> st.sticky[22])
      else $error("card flag lost");

   a_ata_sticky: assert property (@(posedge pclk) disable iff (!presetn)
      event_pulse[23] |=> st.sticky[23])
      else $error("completion flag lost");

   a_sticky_hold: assert property (@(posedge pclk) disable iff (!presetn)
      st.sticky[0] && !(wr_acc && paddr == SHM_OFF_CLEAR) |=> st.sticky[0])
      else $error("sticky flag dropped");

   a_clear_sticky: assert property (@(posedge pclk) disable iff (!presetn)
      s_clear_write ##0 event_pulse == 24'h00_0000 |=> (st.sticky & $past(pwdata[23:0])) == 24'h00_0000)
      else $error("clear did not clear");

   a_set_beats_clear: assert property (@(posedge pclk) disable iff (!presetn)
      s_clear_write ##0 event_pulse[0] |=> st.sticky[0])
      else $error("clear beat a new event");

   a_read_status: assert property (@(posedge pclk) disable iff (!presetn)
      s_setup_read ##0 paddr == SHM_OFF_STATUS |=> st.prdata == {8'h00, $past(flags)})
      else $error("status read wrong");

   // Word counter
   a_read_count: assert property (@(posedge pclk) disable iff (!presetn)
      s_setup_read ##0 paddr == SHM_OFF_WORDCNT |=> st.prdata == {8'h00, $past(st.count)})
      else $error("count read wrong");

   a_count_idle: assert property (@(posedge pclk) disable iff (!presetn)
      !len_load && !word_moved |=> $stable(st.count))
      else $error("count moved by itself");

   a_count_floor: assert property (@(posedge pclk) disable iff (!presetn)
      !len_load && st.count == 24'h00_0000 |=> st.count == 24'h00_0000)
      else $error("count went below zero");

   a_count_ro: assert property (@(posedge pclk) disable iff (!presetn)
      wr_acc && paddr == SHM_OFF_WORDCNT && !len_load && !word_moved |=> $stable(st.count))
      else $error("count was written");

   a_load_wins: assert property (@(posedge pclk) disable iff (!presetn)
      s_count_load ##0 word_moved |=> st.count == shm_words($past(len_bytes)))
      else $error("step beat a load");

   // Read data holds until the next setup read
   a_read_hold: assert property (@(posedge pclk) disable iff (!presetn)
      !(psel && !penable && !pwrite) |=> $stable(st.prdata))
      else $error("read data changed");

   // FIFO data port strobes
   a_fifo_pop: assert property (@(posedge pclk) disable iff (!presetn)
      rd_acc && paddr == SHM_OFF_FIFODATA |-> rx_pop && prdata == rx_data)
      else $error("fifo pop missing");

   a_no_stray_pop: assert property (@(posedge pclk) disable iff (!presetn)
      !(rd_acc && paddr == SHM_OFF_FIFODATA) |-> !rx_pop)
      else $error("stray fifo pop");

   a_no_stray_push: assert property (@(posedge pclk) disable iff (!presetn)
      !(wr_acc && paddr == SHM_OFF_FIFODATA) |-> !tx_push)
      else $error("stray fifo push");

   a_push_pop_apart: assert property (@(posedge pclk) disable iff (!presetn)
      tx_push |-> !rx_pop)
      else $error("push and pop together");
endmodule : shm_regs

// [tb.sv]
// Testbench for the SD host mask, FIFO counter and FIFO port bank
`timescale 1ns/1ps
module tb;
   import shm_pkg::*;
   logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, rx_data = 32'hA5C3_0F1E, prdata, tx_data, q, seen_tx;
   logic        pready, pslverr, tx_push, rx_pop, irq, err, stb, rdy, len_load = 0, word_moved = 0;
   logic [23:0] event_pulse = '0;
   shm_live_t   live = '0;
   logic [5:0]  tx_level = 6'h1E;
   logic [24:0] len_bytes = '0;
   int          err_count = 0, checks_done = 0;
   shm_regs #(.TX_DEPTH(32)) dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .event_pulse(event_pulse), .live(live), .tx_level(tx_level), .len_load(len_load),
      .len_bytes(len_bytes), .word_moved(word_moved), .tx_push(tx_push), .tx_data(tx_data),
      .rx_pop(rx_pop), .rx_data(rx_data), .irq(irq));
   initial forever #2 pclk = ~pclk;
   task automatic print_verdict;
      if (err_count == 0 && checks_done > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : print_verdict
   task automatic chk(input string name, input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         err_count++;
         $display("BAD %s expected %h seen %h", name, exp, got);
      end
   endtask : chk
   // Answer taken at the rising edge that sees pready, before that edge's updates land
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         rdy = pready;
         q = prdata;
         err = pslverr;
         seen_tx = tx_data;
         stb = w ? tx_push : rx_pop;
         n++;
      end while (rdy !== 1'b1 && n < 50);
      if (rdy !== 1'b1) err_count++;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb
   task automatic see_irq(input logic e);
      @(negedge pclk);
      chk("irq", {31'h0, irq}, {31'h0, e});
      @(posedge pclk);
   endtask : see_irq
   initial begin
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(0, SHM_OFF_MASK, 0);
      chk("mask_reset", q, 32'h0);
      apb(0, SHM_OFF_WORDCNT, 0);
      chk("count_reset", q, 32'h0);
      apb(1, SHM_OFF_MASK, 32'hFFFF_FFFF);
      apb(0, SHM_OFF_MASK, 0);
      chk("mask_rw", q, 32'h00FF_FFFF);
      for (int i = 0; i < 24; i++) begin
         if (i < 11 || i > 21) begin
            apb(1, SHM_OFF_MASK, ~(32'h1 << i));
            event_pulse[i] <= 1'b1;
            @(posedge pclk);
            event_pulse <= '0;
            repeat (2) @(posedge pclk);
            see_irq(0);
            apb(0, SHM_OFF_STATUS, 0);
            chk("sticky", q, 32'h1 << i);
            apb(1, SHM_OFF_MASK, 32'h1 << i);
            see_irq(1);
            apb(1, SHM_OFF_CLEAR, 32'h1 << i);
            see_irq(0);
         end
      end
      apb(1, SHM_OFF_MASK, 0);
      live <= '1;
      @(posedge pclk);
      apb(0, SHM_OFF_STATUS, 0);
      chk("live", q, 32'h003F_B800);
      live     <= '0;
      tx_level <= 6'h18;
      @(posedge pclk);
      apb(0, SHM_OFF_STATUS, 0);
      chk("half_empty", q, 32'h0000_4000);
      apb(1, SHM_OFF_MASK, 32'h0000_4000);
      see_irq(1);
      // One word short of the eight-word room
      tx_level <= 6'h19;
      repeat (2) @(posedge pclk);
      see_irq(0);
      presetn <= 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(0, SHM_OFF_MASK, 0);
      chk("mask_rst2", q, 32'h0);
      see_irq(0);
      len_bytes <= 25'h5;
      len_load  <= 1'b1;
      @(posedge pclk);
      len_load <= 1'b0;
      @(posedge pclk);
      apb(0, SHM_OFF_WORDCNT, 0);
      chk("count_ceil", q, 32'h2);
      word_moved <= 1'b1;
      @(posedge pclk);
      word_moved <= 1'b0;
      apb(1, SHM_OFF_WORDCNT, 32'hFF);
      apb(0, SHM_OFF_WORDCNT, 0);
      chk("count_ro", q, 32'h1);
      apb(0, SHM_OFF_FIFODATA, 0);
      chk("rx_word", q, 32'hA5C3_0F1E);
      chk("rx_pop", {31'h0, stb}, 32'h1);
      apb(1, SHM_OFF_FIFODATA, 32'h1234_5678);
      chk("tx_word", seen_tx, 32'h1234_5678);
      chk("tx_push", {31'h0, stb}, 32'h1);
      apb(0, 12'h040, 0);
      chk("unmapped", {31'h0, err}, 32'h1);
      print_verdict;
   end
   initial begin
      repeat (20000) @(posedge pclk);
      err_count++;
      print_verdict;
   end
endmodule : tb
